// *** logic/reset_source_controller.sv ***
// Purpose: gathers reset sources, sequences system reset, records the last cause
// Assumes: i_rst is power-on reset; monitored clock and pins are asynchronous
// Notes: one Avalon-MM register, waitrequest answered from a flop
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module reset_source_controller #(
   parameter int CLOCK_LOSS_CYCLES = reset_source_pkg::CLOCK_LOSS_CYCLES
) (
   // clock and power-on reset
   input wire logic i_clock,
   input wire logic i_rst,
   // avalon-mm slave
   input wire logic [reset_source_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // asynchronous pins and analog levels
   input wire logic i_rst_pin_n,
   input wire logic i_monitored_clock,
   input wire logic i_bus_supply_level,
   input wire logic i_supply_low,
   // same-domain core and flash events
   input wire logic i_program_store_write_enable,
   input wire logic i_ext_data_write,
   input wire logic [15:0] i_ext_data_addr,
   input wire logic i_code_read,
   input wire logic [15:0] i_code_read_addr,
   input wire logic i_branch,
   input wire logic [15:0] i_branch_addr,
   input wire logic i_flash_security_violation,
   // same-domain usb and regulator
   input wire logic i_usb_enabled,
   input wire logic i_usb_bus_reset,
   input wire logic i_bus_supply_polarity_select,
   // reset results
   output logic o_system_reset,
   output logic o_clock_loss_detector_enable,
   output var reset_source_pkg::cause_s o_cause
);

   localparam int START_LAST = reset_source_pkg::START_DELAY_CYCLES - 1;

   // synchronisers: pin, monitored clock, bus supply, supply low
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic mon_prev_q;
   logic [reset_source_pkg::LOSS_CNT_W-1:0] loss_cnt_q;
   logic [reset_source_pkg::DELAY_CNT_W-1:0] dly_cnt_q;
   logic clock_loss_en_q;
   logic usb_sel_q;
   logic supply_sel_q;
   reset_source_pkg::cause_s cause_q;
   reset_source_pkg::cause_s cause_d;
   reset_source_pkg::seq_e seq_q;
   reset_source_pkg::seq_e seq_d;
   logic sys_rst_q;
   logic wait_q;
   logic [31:0] rdata_q;

   logic pin_active;
   logic supply_active;
   logic bus_supply_active;
   logic mon_edge;
   logic clock_loss_hit;
   logic flash_err;
   logic usb_bus_event;
   logic soft_req;
   logic held;
   logic any_req;
   logic addr_hit;
   logic wr_hit;
   logic running;

   // input synchronisers
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sync1_q <= reset_source_pkg::SYNC_RESET;
         sync2_q <= reset_source_pkg::SYNC_RESET;
      end else begin
         sync1_q <= {i_supply_low, i_bus_supply_level, i_monitored_clock, i_rst_pin_n};
         sync2_q <= sync1_q;
      end
   end

   assign running = (seq_q == reset_source_pkg::SEQ_RUN);
   // pin is only ever sampled, never driven
   assign pin_active = ~sync2_q[0];
   assign supply_active = supply_sel_q & sync2_q[3];
   assign bus_supply_active = usb_sel_q & (sync2_q[2] == i_bus_supply_polarity_select);
   assign usb_bus_event = usb_sel_q & i_usb_enabled & i_usb_bus_reset;

   // flash fault checks
   always_comb begin
      flash_err = 1'b0;
      if (i_program_store_write_enable && i_ext_data_write && i_ext_data_addr > reset_source_pkg::CODE_SPACE_LIMIT) begin
         flash_err = 1'b1;
      end
      if (i_code_read && i_code_read_addr > reset_source_pkg::CODE_SPACE_LIMIT) begin
         flash_err = 1'b1;
      end
      if (i_branch && i_branch_addr > reset_source_pkg::CODE_SPACE_LIMIT) begin
         flash_err = 1'b1;
      end
      if (i_flash_security_violation) begin
         flash_err = 1'b1;
      end
   end

   // clock-loss one-shot
   assign mon_edge = sync2_q[1] & ~mon_prev_q;
   assign clock_loss_hit = clock_loss_en_q && (loss_cnt_q == reset_source_pkg::LOSS_CNT_W'(CLOCK_LOSS_CYCLES));

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         mon_prev_q <= 1'b0;
         loss_cnt_q <= '0;
      end else begin
         mon_prev_q <= sync2_q[1];
         if (!clock_loss_en_q || mon_edge) begin
            loss_cnt_q <= '0;
         end else if (!clock_loss_hit) begin
            loss_cnt_q <= loss_cnt_q + 1'b1;
         end
      end
   end

   // bus decode
   assign addr_hit = (i_avs_address == reset_source_pkg::RESET_CAUSE_ADDR);
   assign wr_hit = i_avs_write && !wait_q && addr_hit && i_avs_byteenable[0];
   assign soft_req = wr_hit && i_avs_writedata[reset_source_pkg::BIT_SOFT];

   assign held = pin_active | supply_active | bus_supply_active | clock_loss_hit;
   assign any_req = held | flash_err | soft_req | usb_bus_event;

   // reset sequencer
   always_comb begin
      seq_d = seq_q;
      unique case (seq_q)
         reset_source_pkg::SEQ_RUN: begin
            if (any_req) begin
               seq_d = reset_source_pkg::SEQ_HOLD;
            end
         end
         reset_source_pkg::SEQ_HOLD: begin
            if (!held) begin
               seq_d = reset_source_pkg::SEQ_DELAY;
            end
         end
         reset_source_pkg::SEQ_DELAY: begin
            if (held) begin
               seq_d = reset_source_pkg::SEQ_HOLD;
            end else if (dly_cnt_q == reset_source_pkg::DELAY_CNT_W'(START_LAST)) begin
               seq_d = reset_source_pkg::SEQ_RUN;
            end
         end
         default: begin
            seq_d = reset_source_pkg::SEQ_HOLD;
         end
      endcase
   end

   // cause capture, one flag only, by priority
   always_comb begin
      cause_d = reset_source_pkg::CAUSE_NONE;
      if (pin_active) begin
         cause_d.pin_reset_flag = 1'b1;
      end else if (supply_active) begin
         cause_d.power_on_reset_flag = 1'b1;
      end else if (clock_loss_hit) begin
         cause_d.clock_loss_reset_flag = 1'b1;
      end else if (flash_err) begin
         cause_d.flash_fault_flag = 1'b1;
      end else if (bus_supply_active || usb_bus_event) begin
         cause_d.usb_reset_flag = 1'b1;
      end else begin
         cause_d.soft_reset_flag = 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         seq_q <= reset_source_pkg::SEQ_DELAY;
         sys_rst_q <= 1'b1;
      end else begin
         seq_q <= seq_d;
         sys_rst_q <= (seq_d != reset_source_pkg::SEQ_RUN);
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         dly_cnt_q <= '0;
      end else if (seq_q != reset_source_pkg::SEQ_DELAY || held) begin
         dly_cnt_q <= '0;
      end else begin
         dly_cnt_q <= dly_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cause_q <= reset_source_pkg::CAUSE_RESET;
      end else if (running && any_req) begin
         cause_q <= cause_d;
      end
   end

   // enables: kept apart from cause flags; system reset drops usb and clock-loss
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         clock_loss_en_q <= reset_source_pkg::CLOCK_LOSS_EN_RESET;
         usb_sel_q <= reset_source_pkg::USB_SEL_RESET;
         supply_sel_q <= reset_source_pkg::SUPPLY_SEL_RESET;
      end else if (!running || any_req) begin
         clock_loss_en_q <= reset_source_pkg::CLOCK_LOSS_EN_RESET;
         usb_sel_q <= reset_source_pkg::USB_SEL_RESET;
      end else if (wr_hit) begin
         clock_loss_en_q <= i_avs_writedata[reset_source_pkg::BIT_CLOCK_LOSS];
         usb_sel_q <= i_avs_writedata[reset_source_pkg::BIT_USB];
         supply_sel_q <= i_avs_writedata[reset_source_pkg::BIT_SUPPLY];
      end
   end

   // bus slave: one wait cycle, read data registered with it
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wait_q <= 1'b1;
         rdata_q <= '0;
      end else begin
         wait_q <= !((i_avs_read || i_avs_write) && wait_q);
         if (i_avs_read && wait_q) begin
            rdata_q <= addr_hit ? {24'h0, cause_q} : 32'h0;
         end
      end
   end

   assign o_avs_readdata = rdata_q;
   assign o_avs_waitrequest = wait_q;
   assign o_system_reset = sys_rst_q;
   assign o_clock_loss_detector_enable = clock_loss_en_q;
   assign o_cause = cause_q;

   // checks
   a_pin_enters_reset: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && pin_active) |=> o_system_reset)
      else $error("pin low did not start reset");

   a_pin_flag_only: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && pin_active) |=> (o_cause == 8'h01))
      else $error("pin cause not captured alone");

   a_clock_loss_reset: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && clock_loss_hit && !pin_active && !supply_active) |=> o_system_reset ##0 (o_cause == 8'h04))
      else $error("clock loss timeout did not reset");

   a_clock_loss_count: assert property (@(posedge i_clock) disable iff (i_rst)
      clock_loss_hit |-> $past(clock_loss_en_q) && !$past(mon_edge))
      else $error("clock loss fired after an edge");

   a_loss_enable_write: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && !any_req && wr_hit) |=> (o_clock_loss_detector_enable == $past(i_avs_writedata[2])))
      else $error("clock loss enable not written");

   a_flash_reset: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && flash_err && !held) |=> o_system_reset ##0 (o_cause == 8'h40))
      else $error("flash fault reset missing");

   a_soft_reset: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && soft_req && !held && !flash_err && !usb_bus_event) |=> o_system_reset ##0 (o_cause == 8'h10))
      else $error("software reset missing");

   a_usb_gated: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && !usb_sel_q && !pin_active && !supply_active && !clock_loss_hit && !flash_err && !soft_req)
      |=> !o_system_reset)
      else $error("reset without selected source");

   a_unused_zero: assert property (@(posedge i_clock) disable iff (i_rst)
      !o_avs_waitrequest |-> (o_avs_readdata[5] == 1'b0) && (o_avs_readdata[3] == 1'b0))
      else $error("unused bits not zero");

   a_start_delay: assert property (@(posedge i_clock) disable iff (i_rst)
      $fell(o_system_reset) |-> ($past(dly_cnt_q) == START_LAST) && $past(seq_q, 2) == reset_source_pkg::SEQ_DELAY)
      else $error("code start before delay");

   a_hold_while_active: assert property (@(posedge i_clock) disable iff (i_rst)
      (!running && held) |=> o_system_reset)
      else $error("reset released with active source");

   a_ext_write_fault: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && !held && i_program_store_write_enable && i_ext_data_write
         && (i_ext_data_addr > reset_source_pkg::CODE_SPACE_LIMIT)) |=> o_system_reset ##0 (o_cause == 8'h40))
      else $error("store write above code space did not reset");

   a_code_read_fault: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && !held && i_code_read && (i_code_read_addr > reset_source_pkg::CODE_SPACE_LIMIT))
      |=> o_system_reset ##0 (o_cause == 8'h40))
      else $error("code read above code space did not reset");

   a_branch_fault: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && !held && i_branch && (i_branch_addr > reset_source_pkg::CODE_SPACE_LIMIT))
      |=> o_system_reset ##0 (o_cause == 8'h40))
      else $error("branch above code space did not reset");

   a_security_fault: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && !held && i_flash_security_violation) |=> o_system_reset ##0 (o_cause == 8'h40))
      else $error("security violation did not reset");

   a_soft_zero_write: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && wr_hit && !i_avs_writedata[reset_source_pkg::BIT_SOFT]
         && !held && !flash_err && !usb_bus_event)
      |=> !o_system_reset)
      else $error("zero written to soft bit caused reset");

   a_usb_bus_reset: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && usb_bus_event && !pin_active && !supply_active && !clock_loss_hit && !flash_err)
      |=> o_system_reset ##0 (o_cause == 8'h80))
      else $error("usb bus reset did not reset");

   a_bus_supply_reset: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && bus_supply_active && !pin_active && !supply_active && !clock_loss_hit && !flash_err)
      |=> o_system_reset ##0 (o_cause == 8'h80))
      else $error("bus supply match did not reset");

   a_supply_reset: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && supply_sel_q && sync2_q[3] && !pin_active) |=> o_system_reset ##0 (o_cause == 8'h02))
      else $error("selected supply monitor did not reset");

   a_cause_frozen: assert property (@(posedge i_clock) disable iff (i_rst)
      !running |=> $stable(o_cause))
      else $error("cause changed during reset");

   a_enable_apart: assert property (@(posedge i_clock) disable iff (i_rst)
      (running && wr_hit && !any_req) |=> $stable(o_cause))
      else $error("enable write altered cause");

   a_loss_restart: assert property (@(posedge i_clock) disable iff (i_rst)
      (clock_loss_en_q && mon_edge) |=> (loss_cnt_q == '0))
      else $error("clock loss counter did not restart");

   c_pin_reset: cover property (@(posedge i_clock) disable iff (i_rst) running && pin_active);
   c_clock_loss: cover property (@(posedge i_clock) disable iff (i_rst) running && clock_loss_hit);
   c_soft_reset: cover property (@(posedge i_clock) disable iff (i_rst) running && soft_req);
   c_flash_reset: cover property (@(posedge i_clock) disable iff (i_rst) running && flash_err);
   c_usb_reset: cover property (@(posedge i_clock) disable iff (i_rst) running && (usb_bus_event || bus_supply_active));

endmodule
`default_nettype wire

// *** pkg/reset_source_pkg.sv ***
// Purpose: constants and types shared by the reset source controller
// Assumes: 100 MHz system reference clock
// Notes: cause register index is 0xef, its byte address is four times that
`default_nettype none
package reset_source_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int CLOCK_LOSS_TIMEOUT_US = 100;
   localparam int CLOCK_LOSS_CYCLES = (CLOCK_LOSS_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_DELAY_NS = 5000;
   localparam int START_DELAY_CYCLES = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOSS_CNT_W = 16;
   localparam int DELAY_CNT_W = 10;

   // register bus
   localparam int ADDR_W = 12;
   localparam logic [7:0] RESET_CAUSE_INDEX = 8'hef;
   localparam logic [ADDR_W-1:0] RESET_CAUSE_ADDR = {2'h0, RESET_CAUSE_INDEX, 2'h0};

   // reset cause register fields
   localparam int BIT_PIN = 0;
   localparam int BIT_SUPPLY = 1;
   localparam int BIT_CLOCK_LOSS = 2;
   localparam int BIT_SOFT = 4;
   localparam int BIT_FLASH = 6;
   localparam int BIT_USB = 7;

   // enables after power-on
   localparam logic SUPPLY_SEL_RESET = 1'b1;
   localparam logic CLOCK_LOSS_EN_RESET = 1'b0;
   localparam logic USB_SEL_RESET = 1'b0;

   // top of user code space
   localparam logic [15:0] CODE_SPACE_LIMIT = 16'h3dff;

   // synchroniser reset values: pin idles high, others low
   localparam logic [3:0] SYNC_RESET = 4'h1;

   typedef struct packed {
      logic usb_reset_flag;
      logic flash_fault_flag;
      logic unused5;
      logic soft_reset_flag;
      logic unused3;
      logic clock_loss_reset_flag;
      logic power_on_reset_flag;
      logic pin_reset_flag;
   } cause_s;

   localparam cause_s CAUSE_RESET = 8'h02;
   localparam cause_s CAUSE_NONE = 8'h00;

   typedef enum logic [1:0] {
      SEQ_RUN = 2'b00,
      SEQ_HOLD = 2'b01,
      SEQ_DELAY = 2'b10
   } seq_e;
endpackage
`default_nettype wire

// *** test/reset_partner_model.sv ***
// Purpose: far side of the controller: reset pin, watched clock, supply levels
// Assumes: stepped from the bench clock
// Notes: the pin has a pull-up, so it idles high between requests
`timescale 1ns/10ps
`default_nettype none
module reset_partner_model #(
   parameter int PIN_LOW_CYCLES = 1500
) (
   // control from the bench
   input wire logic i_clock,
   input wire logic i_pin_req,
   input wire logic i_clk_stop,
   input wire logic i_vbus,
   input wire logic i_sup_low,
   // lines toward the device
   output logic o_rst_pin_n,
   output logic o_mon_clock,
   output logic o_bus_supply_level,
   output logic o_supply_low
);
   int pin_cnt = 0;
   logic [1:0] div_q = 2'h0;
   always @(posedge i_clock) begin
      if (i_pin_req) begin
         pin_cnt <= PIN_LOW_CYCLES;
      end else if (pin_cnt > 0) begin
         pin_cnt <= pin_cnt - 1;
      end
      if (!i_clk_stop) begin
         div_q <= div_q + 2'h1;
      end
   end
   assign o_rst_pin_n = (pin_cnt == 0);
   assign o_mon_clock = div_q[1];
   assign o_bus_supply_level = i_vbus;
   assign o_supply_low = i_sup_low;
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: self-checking bench for the reset source controller
// Assumes: clock-loss count shortened to 20 cycles
// Notes: every reset costs the 500-cycle start delay
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int LIMIT = 30000;
   localparam logic [11:0] REG = reset_source_pkg::RESET_CAUSE_ADDR;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [11:0] address = 12'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic pin_req = 1'b0;
   logic clk_stop = 1'b0;
   logic vbus = 1'b1;
   logic sup_low = 1'b0;
   logic pin_n, mon_clk, bus_lvl, sup_lo, sysrst, det_en;
   logic program_store_write_enable = 1'b0;
   logic usb_en = 1'b0;
   logic pol = 1'b0;
   logic [4:0] ev = 5'h00;
   logic [15:0] fa = 16'h0000;
   reset_source_pkg::cause_s cause;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   int n;

   initial begin
      forever #5 clock = ~clock;
   end

   reset_partner_model u_far (.i_clock(clock), .i_pin_req(pin_req), .i_clk_stop(clk_stop), .i_vbus(vbus),
      .i_sup_low(sup_low), .o_rst_pin_n(pin_n), .o_mon_clock(mon_clk), .o_bus_supply_level(bus_lvl),
      .o_supply_low(sup_lo));

   reset_source_controller #(.CLOCK_LOSS_CYCLES(20)) u_dut (.i_clock(clock), .i_rst(rst),
      .i_avs_address(address), .i_avs_read(read), .i_avs_write(write), .i_avs_writedata(writedata),
      .i_avs_byteenable(4'hf), .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest),
      .i_rst_pin_n(pin_n), .i_monitored_clock(mon_clk), .i_bus_supply_level(bus_lvl), .i_supply_low(sup_lo),
      .i_program_store_write_enable(program_store_write_enable), .i_ext_data_write(ev[0]), .i_ext_data_addr(fa),
      .i_code_read(ev[1]), .i_code_read_addr(fa), .i_branch(ev[2]), .i_branch_addr(fa),
      .i_flash_security_violation(ev[3]), .i_usb_enabled(usb_en), .i_usb_bus_reset(ev[4]),
      .i_bus_supply_polarity_select(pol), .o_system_reset(sysrst), .o_clock_loss_detector_enable(det_en),
      .o_cause(cause));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clock);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= {24'h0, d};
      do begin
         @(posedge clock);
         k++;
      end while (waitrequest !== 1'b0 && k < 50);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      check("bus answer", {31'h0, waitrequest}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, REG, d, q);
   endtask

   task automatic cause_is(input string name, input logic [7:0] exp);
      logic [31:0] q;
      bus(1'b0, REG, 8'h00, q);
      check(name, q, {24'h0, exp});
      check("cause port", {24'h0, cause}, {24'h0, exp});
   endtask

   task automatic wait_rst(input logic lvl, input int max, output int k);
      k = 0;
      while (sysrst !== lvl && k < max) begin
         @(posedge clock);
         k++;
      end
      check("reset level", {31'h0, sysrst}, {31'h0, lvl});
   endtask

   task automatic finish_reset(input string name, input logic [7:0] exp);
      int k;
      wait_rst(1'b0, 3000, k);
      check("start delay", {31'h0, k >= reset_source_pkg::START_DELAY_CYCLES - 1}, 32'h1);
      cause_is(name, exp);
   endtask

   task automatic no_reset(input string name, input int cycles);
      logic seen;
      seen = 1'b0;
      repeat (cycles) begin
         @(posedge clock);
         seen = seen | sysrst;
      end
      check(name, {31'h0, seen}, 32'h0);
   endtask

   // one-cycle event: 0..3 flash kinds, 4 usb bus reset
   task automatic pulse(input int kind, input logic [15:0] a, input logic en);
      @(posedge clock);
      program_store_write_enable <= en;
      fa <= a;
      ev <= 5'h01 << kind;
      @(posedge clock);
      ev <= 5'h00;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         results();
      end
   end

   initial begin
      logic [31:0] q;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      wait_rst(1'b0, 700, n);
      cause_is("power on", 8'h02);
      check("detector off", {31'h0, det_en}, 32'h0);
      bus(1'b0, REG ^ 12'h004, 8'h00, q);
      check("unmapped", q, 32'h0);
      bus(1'b1, REG ^ 12'h004, 8'h10, q);
      no_reset("unmapped write", 20);
      wr(8'h28);
      cause_is("unused bits", 8'h02);
      wr(8'h00);
      no_reset("write zero", 40);
      wr(8'h10);
      wait_rst(1'b1, 100, n);
      check("pin untouched", {31'h0, pin_n}, 32'h1);
      finish_reset("soft", 8'h10);
      sup_low <= 1'b1;
      no_reset("supply unselected", 40);
      wr(8'h02);
      wait_rst(1'b1, 100, n);
      sup_low <= 1'b0;
      finish_reset("supply", 8'h02);
      @(posedge clock);
      pin_req <= 1'b1;
      @(posedge clock);
      pin_req <= 1'b0;
      wait_rst(1'b1, 100, n);
      pulse(1, 16'h3e00, 1'b0);
      finish_reset("pin", 8'h01);
      for (int k = 0; k < 4; k++) begin
         if (k < 3) begin
            pulse(k, 16'h3dff, 1'b1);
            no_reset("flash limit", 20);
         end
         pulse(k, 16'h3e00, 1'b1);
         wait_rst(1'b1, 100, n);
         finish_reset("flash", 8'h40);
      end
      pulse(0, 16'hffff, 1'b0);
      no_reset("store write off", 20);
      wr(8'h04);
      no_reset("clock running", 60);
      check("detector on", {31'h0, det_en}, 32'h1);
      cause_is("cause kept", 8'h40);
      wr(8'h00);
      clk_stop <= 1'b1;
      no_reset("detector disabled", 60);
      check("detector off", {31'h0, det_en}, 32'h0);
      clk_stop <= 1'b0;
      no_reset("clock back", 8);
      wr(8'h04);
      clk_stop <= 1'b1;
      wait_rst(1'b1, 100, n);
      clk_stop <= 1'b0;
      finish_reset("clock loss", 8'h04);
      usb_en <= 1'b1;
      pulse(4, 16'h0000, 1'b0);
      no_reset("usb unselected", 20);
      wr(8'h80);
      usb_en <= 1'b0;
      pulse(4, 16'h0000, 1'b0);
      no_reset("usb disabled", 20);
      usb_en <= 1'b1;
      pulse(4, 16'h0000, 1'b0);
      wait_rst(1'b1, 100, n);
      finish_reset("usb bus reset", 8'h80);
      pol <= 1'b1;
      no_reset("polarity unselected", 20);
      wr(8'h80);
      wait_rst(1'b1, 100, n);
      pol <= 1'b0;
      finish_reset("usb supply", 8'h80);
      results();
   end
endmodule
`default_nettype wire
